// [monitor_config_pkg.sv]
// Constants and types for the monitor configuration store
package monitor_config_pkg;
   // ====================================================
   // Parameter numbers
   localparam logic [7:0] PARAM_EXT_PRESSURE = 8'h20;
   localparam logic [7:0] PARAM_INT_UNIT = 8'h21;
   localparam logic [7:0] PARAM_A_UNIT = 8'h22;
   localparam logic [7:0] PARAM_B_UNIT = 8'h23;
   localparam logic [7:0] PARAM_OUT_SIGNAL = 8'h24;
   localparam logic [7:0] PARAM_A_SIGNAL = 8'h25;
   localparam logic [7:0] PARAM_B_SIGNAL = 8'h26;
   localparam logic [7:0] PARAM_SOUND = 8'h27;
   localparam logic [7:0] PARAM_SOUND_LEN = 8'h28;
   localparam logic [7:0] PARAM_DEC_P = 8'h29;
   localparam logic [7:0] PARAM_DEC_AT = 8'h2A;
   localparam logic [7:0] PARAM_DEC_AP = 8'h2B;
   localparam logic [7:0] PARAM_DEC_BH = 8'h2C;
   localparam logic [7:0] PARAM_DEC_BP = 8'h2D;
   localparam logic [7:0] PARAM_RELAY_MASK = 8'h2E;
   localparam logic [7:0] PARAM_RELAY1_TIME = 8'h2F;
   localparam logic [7:0] PARAM_RELAY2_TIME = 8'h30;
   localparam logic [7:0] PARAM_RELAY_ACK = 8'h31;
   localparam logic [7:0] PARAM_DEV_ADDR = 8'h32;
   // ====================================================
   // Field layout and reset values
   localparam int MASK_B = 0;
   localparam int MASK_A = 1;
   localparam int MASK_P = 2;
   localparam logic [1:0] CODE_MAX_SIGNAL = 2'h2;
   localparam logic [2:0] CODE_MAX_MASK = 3'h7;
   localparam logic [1:0] RST_CODE2 = 2'h0;
   localparam logic [2:0] RST_MASK = 3'h0;
   localparam logic [15:0] RST_TIME = 16'h0000;
   localparam logic [7:0] ASCII_CR = 8'h0D;
   localparam int CLOCK_HZ = 25000000;
   localparam int MS_CYCLES = CLOCK_HZ / 1000;
   localparam logic [15:0] MS_CYCLES_M1 = 16'(MS_CYCLES - 1);
   // ====================================================
   // Decoded settings
   typedef enum logic [1:0] {unit_base, unit_hpa, unit_mbar, unit_off} unit_e;
   typedef enum logic [1:0] {sig_0_20ma, sig_4_20ma, sig_0_10v, sig_bad} signal_e;
endpackage : monitor_config_pkg

// [monitor_config_parameters.sv]
// Configuration parameter store with relay delays and warning sound timer
// Functional notes
// - External pressure code selects sensor placement.
// - Internal pressure unit Pa/hPa/mbar/off.
// - Input A unit degC-Pa/hPa/mbar/off.
// - Input B unit rH-Pa/hPa/mbar/off.
// - Output signal 0-20mA, 4-20mA, 0-10V.
// - Input signal types decoded identically.
// - Warning sound lasts configured milliseconds.
// - Decimal enables: 0 hide, 1 show.
// - Mask zero never switches relays.
// - Mask bits select B, A, pressure.
// - Relay one upper limit response time.
// - Relay two lower limit response time.
// - Device address read only from switches.
// - Accepted values apply at once, volatile.
// - Rejected writes answer with error code.
// - Values terminated by carriage return.
`timescale 1ns/100ps
module monitor_config_parameters (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Parameter write port, value already parsed up to its CR
   input wire logic write_strobe,
   input wire logic [7:0] write_param,
   input wire logic [15:0] write_value,
   input wire logic [7:0] write_terminator,
   output logic write_ack,
   output logic write_error,
   // Save request
   input wire logic save_settings_command,
   output logic save_request,
   // Parameter read port
   input wire logic [7:0] read_param,
   output logic [15:0] read_value,
   // Switches and channel limit events
   input wire logic [7:0] bcd_switches,
   input wire logic [2:0] upper_exceeded,
   input wire logic [2:0] lower_exceeded,
   input wire logic warning_event,
   // Decoded settings
   output logic ext_press_a,
   output logic ext_press_b,
   output monitor_config_pkg::unit_e internal_pressure_unit,
   output monitor_config_pkg::unit_e input_a_unit,
   output monitor_config_pkg::unit_e input_b_unit,
   output monitor_config_pkg::signal_e output_signal_type,
   output monitor_config_pkg::signal_e input_a_signal_type,
   output monitor_config_pkg::signal_e input_b_signal_type,
   output logic pressure_decimals_enable,
   output logic input_a_temp_decimals_enable,
   output logic input_a_press_decimals_enable,
   output logic input_b_humid_decimals_enable,
   output logic input_b_press_decimals_enable,
   output logic relay_ack_enable,
   output logic [7:0] device_address,
   // Actuators
   output logic relay_upper,
   output logic relay_lower,
   output logic sound_on
);
   import monitor_config_pkg::*;

   logic [1:0] ext_pressure_placement;
   logic sound_enable;
   logic [15:0] sound_length_ms;
   logic [2:0] relay_channel_mask;
   logic [15:0] relay1_time_ms;
   logic [15:0] relay2_time_ms;
   logic [7:0] sw_meta;
   logic [7:0] sw_sync;
   logic [2:0] up_meta, up_sync, lo_meta, lo_sync;
   logic warn_meta, warn_sync, warn_last;
   logic [15:0] ms_div;
   logic ms_tick;
   logic [15:0] up_count, lo_count, snd_count;
   logic accept;
   logic up_cond, lo_cond, up_armed, lo_armed;

   function automatic logic valid_code(input logic [15:0] v, input logic [15:0] max);
      valid_code = (v <= max);
   endfunction : valid_code

   // ====================================================
   // Write acceptance
   always_comb begin
      unique case (write_param)
         PARAM_EXT_PRESSURE, PARAM_INT_UNIT, PARAM_A_UNIT, PARAM_B_UNIT: accept = valid_code(write_value, 16'h0003);
         PARAM_OUT_SIGNAL, PARAM_A_SIGNAL, PARAM_B_SIGNAL: accept = valid_code(write_value, {14'h0, CODE_MAX_SIGNAL});
         PARAM_SOUND, PARAM_DEC_P, PARAM_DEC_AT, PARAM_DEC_AP, PARAM_DEC_BH, PARAM_DEC_BP, PARAM_RELAY_ACK: begin
            accept = valid_code(write_value, 16'h0001);
         end
         PARAM_RELAY_MASK: accept = valid_code(write_value, {13'h0, CODE_MAX_MASK});
         PARAM_SOUND_LEN, PARAM_RELAY1_TIME, PARAM_RELAY2_TIME: accept = 1'b1;
         default: accept = 1'b0;
      endcase
      if (write_terminator != ASCII_CR) begin
         accept = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         write_ack <= 1'b0;
         write_error <= 1'b0;
         save_request <= 1'b0;
      end else begin
         write_ack <= write_strobe && accept;
         write_error <= write_strobe && !accept;
         save_request <= save_settings_command;
      end
   end

   // ====================================================
   // Working storage, effective the cycle after acceptance
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ext_pressure_placement <= RST_CODE2;
         internal_pressure_unit <= unit_base;
         input_a_unit <= unit_base;
         input_b_unit <= unit_base;
         output_signal_type <= sig_0_20ma;
         input_a_signal_type <= sig_0_20ma;
         input_b_signal_type <= sig_0_20ma;
         sound_enable <= 1'b0;
         sound_length_ms <= RST_TIME;
         pressure_decimals_enable <= 1'b0;
         input_a_temp_decimals_enable <= 1'b0;
         input_a_press_decimals_enable <= 1'b0;
         input_b_humid_decimals_enable <= 1'b0;
         input_b_press_decimals_enable <= 1'b0;
         relay_channel_mask <= RST_MASK;
         relay1_time_ms <= RST_TIME;
         relay2_time_ms <= RST_TIME;
         relay_ack_enable <= 1'b0;
      end else if (write_strobe && accept) begin
         unique case (write_param)
            PARAM_EXT_PRESSURE: ext_pressure_placement <= write_value[1:0];
            PARAM_INT_UNIT: internal_pressure_unit <= unit_e'(write_value[1:0]);
            PARAM_A_UNIT: input_a_unit <= unit_e'(write_value[1:0]);
            PARAM_B_UNIT: input_b_unit <= unit_e'(write_value[1:0]);
            PARAM_OUT_SIGNAL: output_signal_type <= signal_e'(write_value[1:0]);
            PARAM_A_SIGNAL: input_a_signal_type <= signal_e'(write_value[1:0]);
            PARAM_B_SIGNAL: input_b_signal_type <= signal_e'(write_value[1:0]);
            PARAM_SOUND: sound_enable <= write_value[0];
            PARAM_SOUND_LEN: sound_length_ms <= write_value;
            PARAM_DEC_P: pressure_decimals_enable <= write_value[0];
            PARAM_DEC_AT: input_a_temp_decimals_enable <= write_value[0];
            PARAM_DEC_AP: input_a_press_decimals_enable <= write_value[0];
            PARAM_DEC_BH: input_b_humid_decimals_enable <= write_value[0];
            PARAM_DEC_BP: input_b_press_decimals_enable <= write_value[0];
            PARAM_RELAY_MASK: relay_channel_mask <= write_value[2:0];
            PARAM_RELAY1_TIME: relay1_time_ms <= write_value;
            PARAM_RELAY2_TIME: relay2_time_ms <= write_value;
            PARAM_RELAY_ACK: relay_ack_enable <= write_value[0];
            default: ;
         endcase
      end
   end

   assign ext_press_a = ext_pressure_placement[1];
   assign ext_press_b = ext_pressure_placement[0];

   // ====================================================
   // Synchronisers for switches and limit events
   always_ff @(posedge clock) begin
      if (!rstn) begin
         sw_meta <= 8'h00;
         sw_sync <= 8'h00;
         up_meta <= 3'h0;
         up_sync <= 3'h0;
         lo_meta <= 3'h0;
         lo_sync <= 3'h0;
         warn_meta <= 1'b0;
         warn_sync <= 1'b0;
      end else begin
         sw_meta <= bcd_switches;
         sw_sync <= sw_meta;
         up_meta <= upper_exceeded;
         up_sync <= up_meta;
         lo_meta <= lower_exceeded;
         lo_sync <= lo_meta;
         warn_meta <= warning_event;
         warn_sync <= warn_meta;
      end
   end

   // Address follows the switches only, never the host
   always_ff @(posedge clock) begin
      if (!rstn) begin
         device_address <= 8'h00;
      end else begin
         device_address <= sw_sync;
      end
   end

   // ====================================================
   // Millisecond tick shared by all timers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ms_div <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_div == MS_CYCLES_M1);
         ms_div <= (ms_div == MS_CYCLES_M1) ? 16'h0000 : ms_div + 16'h0001;
      end
   end

   // ====================================================
   // Relays: a zero mask selects nothing so both stay off
   assign up_cond = |(up_sync & relay_channel_mask);
   assign lo_cond = |(lo_sync & relay_channel_mask);

   // Condition must hold for the full response time; tick granularity adds up to 1 ms
   always_ff @(posedge clock) begin
      if (!rstn || !up_cond) begin
         up_count <= 16'h0000;
         up_armed <= 1'b0;
         relay_upper <= 1'b0;
      end else if (up_count >= relay1_time_ms) begin
         relay_upper <= 1'b1;
      end else if (ms_tick) begin
         // First tick only lines up with the ms grid, so the delay is never short
         up_armed <= 1'b1;
         up_count <= up_count + 16'(up_armed);
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || !lo_cond) begin
         lo_count <= 16'h0000;
         lo_armed <= 1'b0;
         relay_lower <= 1'b0;
      end else if (lo_count >= relay2_time_ms) begin
         relay_lower <= 1'b1;
      end else if (ms_tick) begin
         lo_armed <= 1'b1;
         lo_count <= lo_count + 16'(lo_armed);
      end
   end

   // ====================================================
   // Warning sound, retriggered by each rising warning
   always_ff @(posedge clock) begin
      if (!rstn) begin
         warn_last <= 1'b0;
         snd_count <= 16'h0000;
         sound_on <= 1'b0;
      end else begin
         warn_last <= warn_sync;
         if (warn_sync && !warn_last && sound_enable && sound_length_ms != 16'h0000) begin
            snd_count <= sound_length_ms;
            sound_on <= 1'b1;
         end else if (!sound_enable || snd_count == 16'h0000) begin
            sound_on <= 1'b0;
         end else if (ms_tick) begin
            snd_count <= snd_count - 16'h0001;
            sound_on <= (snd_count != 16'h0001);
         end
      end
   end

   // ====================================================
   // Readback of working storage
   always_ff @(posedge clock) begin
      if (!rstn) begin
         read_value <= 16'h0000;
      end else begin
         unique case (read_param)
            PARAM_EXT_PRESSURE: read_value <= {14'h0, ext_pressure_placement};
            PARAM_INT_UNIT: read_value <= {14'h0, internal_pressure_unit};
            PARAM_A_UNIT: read_value <= {14'h0, input_a_unit};
            PARAM_B_UNIT: read_value <= {14'h0, input_b_unit};
            PARAM_OUT_SIGNAL: read_value <= {14'h0, output_signal_type};
            PARAM_A_SIGNAL: read_value <= {14'h0, input_a_signal_type};
            PARAM_B_SIGNAL: read_value <= {14'h0, input_b_signal_type};
            PARAM_SOUND: read_value <= {15'h0, sound_enable};
            PARAM_SOUND_LEN: read_value <= sound_length_ms;
            PARAM_DEC_P: read_value <= {15'h0, pressure_decimals_enable};
            PARAM_DEC_AT: read_value <= {15'h0, input_a_temp_decimals_enable};
            PARAM_DEC_AP: read_value <= {15'h0, input_a_press_decimals_enable};
            PARAM_DEC_BH: read_value <= {15'h0, input_b_humid_decimals_enable};
            PARAM_DEC_BP: read_value <= {15'h0, input_b_press_decimals_enable};
            PARAM_RELAY_MASK: read_value <= {13'h0, relay_channel_mask};
            PARAM_RELAY1_TIME: read_value <= relay1_time_ms;
            PARAM_RELAY2_TIME: read_value <= relay2_time_ms;
            PARAM_RELAY_ACK: read_value <= {15'h0, relay_ack_enable};
            PARAM_DEV_ADDR: read_value <= {8'h00, device_address};
            default: read_value <= 16'h0000;
         endcase
      end
   end
endmodule : monitor_config_parameters

// [monitor_config_sva.sv]
// Assertion checker for the monitor configuration store
`timescale 1ns/100ps
module monitor_config_sva
   import monitor_config_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Write port
   input wire logic write_strobe,
   input wire logic [7:0] write_param,
   input wire logic [15:0] write_value,
   input wire logic [7:0] write_terminator,
   input wire logic write_ack,
   input wire logic write_error,
   // Save, switches and limits
   input wire logic save_settings_command,
   input wire logic save_request,
   input wire logic [7:0] bcd_switches,
   input wire logic [7:0] device_address,
   input wire logic [2:0] upper_exceeded,
   // Settings and relays
   input wire logic ext_press_a,
   input wire logic ext_press_b,
   input wire monitor_config_pkg::unit_e internal_pressure_unit,
   input wire logic relay_upper,
   input wire logic relay_lower
);
   // ==========================================================
   // Shadow of the mask, since the mask itself is not a port
   wire logic good = write_strobe && write_terminator == ASCII_CR;
   wire logic mask_ok = good && write_param == PARAM_RELAY_MASK && write_value <= 16'h0007;
   logic [2:0] mask_m;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mask_m <= RST_MASK;
      end else if (mask_ok) begin
         mask_m <= write_value[2:0];
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   mask_ack_a: assert property (mask_ok |=> write_ack && !write_error)
      else $error("legal mask write not acknowledged");
   term_err_a: assert property (write_strobe && write_terminator != ASCII_CR |=> write_error && !write_ack)
      else $error("bad terminator not refused");
   addr_ro_a: assert property (write_strobe && write_param == PARAM_DEV_ADDR |=> write_error && !write_ack)
      else $error("address write not refused");
   range_err_a: assert property (good && write_param == PARAM_OUT_SIGNAL && write_value > 16'h0002 |=> write_error)
      else $error("out of range signal code not refused");
   place_set_a: assert property (write_ack && $past(write_param) == PARAM_EXT_PRESSURE
      |-> {ext_press_a, ext_press_b} == $past(write_value[1:0])) else $error("placement not applied");
   unit_set_a: assert property (write_ack && $past(write_param) == PARAM_INT_UNIT
      |-> internal_pressure_unit == $past(write_value[1:0])) else $error("pressure unit not applied");
   mask_off_a: assert property ((mask_m == 3'h0) [*3] |-> !relay_upper && !relay_lower)
      else $error("relay on with empty mask");
   relay_drop_a: assert property ((upper_exceeded == 3'h0) [*5] |-> !relay_upper)
      else $error("upper relay on without cause");
   switch_addr_a: assert property ($stable(bcd_switches) [*5] |-> device_address == bcd_switches)
      else $error("address does not follow switches");
   save_req_a: assert property (save_settings_command |=> save_request)
      else $error("save request missing");
   cover property (write_ack);
   cover property (write_error);
   cover property ($rose(relay_upper));
endmodule : monitor_config_sva

bind monitor_config_parameters monitor_config_sva monitor_config_sva_inst (.clock, .rstn, .write_strobe,
   .write_param, .write_value, .write_terminator, .write_ack, .write_error, .save_settings_command, .save_request,
   .bcd_switches, .device_address, .upper_exceeded, .ext_press_a, .ext_press_b, .internal_pressure_unit,
   .relay_upper, .relay_lower);

// [monitor_host_model.sv]
// Host model that hands parsed configuration writes to the store
`timescale 1ns/100ps
module monitor_host_model (
   // Clock
   input wire logic clock,
   // Write port toward the store
   output logic write_strobe,
   output logic [7:0] write_param,
   output logic [15:0] write_value,
   output logic [7:0] write_terminator,
   // Answer from the store
   input wire logic write_ack,
   input wire logic write_error
);
   initial begin
      write_strobe = 1'b0;
      write_param = 8'h00;
      write_value = 16'h0000;
      write_terminator = 8'h00;
   end
   // ==========================================================
   // n strobes on successive cycles, values v, v+1; res holds {ack, error} of the last two cycles
   task automatic send(input logic [7:0] p, input logic [15:0] v, input logic [7:0] t, input int n,
                       output logic [3:0] res);
      res = 4'h0;
      @(negedge clock);
      for (int i = 0; i < n; i++) begin
         write_strobe = 1'b1;
         write_param = p;
         write_value = v + 16'(i);
         write_terminator = t;
         @(negedge clock);
         res = {res[1:0], write_ack, write_error};
      end
      write_strobe = 1'b0;
      // Released lines carry the inverse so stale data is never mistaken for a write
      write_param = ~p;
      write_value = ~v;
      write_terminator = ~t;
   endtask : send
endmodule : monitor_host_model

// [tb.sv]
// Self-checking bench for the monitor configuration store
`timescale 1ns/100ps
module tb;
   import monitor_config_pkg::*;
   // ==========================================================
   // Signals
   logic clock = 1'b0, rstn = 1'b0, save_settings_command = 1'b0, warning_event = 1'b0;
   logic [7:0] read_param = 8'h00, bcd_switches = 8'h42, write_param, write_terminator, device_address;
   logic [2:0] upper_exceeded = 3'h0, lower_exceeded = 3'h0;
   logic write_strobe, write_ack, write_error, save_request, ext_press_a, ext_press_b, relay_ack_enable;
   logic [15:0] write_value, read_value, want;
   logic pressure_decimals_enable, input_a_temp_decimals_enable, input_a_press_decimals_enable;
   logic input_b_humid_decimals_enable, input_b_press_decimals_enable, relay_upper, relay_lower, sound_on;
   unit_e internal_pressure_unit, input_a_unit, input_b_unit;
   signal_e output_signal_type, input_a_signal_type, input_b_signal_type;
   int error_cnt = 0, checked = 0;
   logic [3:0] res;
   // Each row: parameter and the highest code it accepts
   typedef struct packed {logic [7:0] p; logic [15:0] top;} row_s;
   row_s rows [17] = '{'{PARAM_EXT_PRESSURE, 16'h0003}, '{PARAM_INT_UNIT, 16'h0003}, '{PARAM_A_UNIT, 16'h0003},
      '{PARAM_B_UNIT, 16'h0003}, '{PARAM_OUT_SIGNAL, 16'h0002}, '{PARAM_A_SIGNAL, 16'h0002},
      '{PARAM_B_SIGNAL, 16'h0002}, '{PARAM_SOUND, 16'h0001}, '{PARAM_DEC_P, 16'h0001}, '{PARAM_DEC_AT, 16'h0001},
      '{PARAM_DEC_AP, 16'h0001}, '{PARAM_DEC_BH, 16'h0001}, '{PARAM_DEC_BP, 16'h0001},
      '{PARAM_RELAY_MASK, 16'h0007}, '{PARAM_RELAY_ACK, 16'h0001}, '{PARAM_RELAY1_TIME, 16'hFFFF},
      '{PARAM_RELAY2_TIME, 16'hFFFF}};
   monitor_config_parameters monitor_config_parameters_inst (.clock, .rstn, .write_strobe, .write_param,
      .write_value, .write_terminator, .write_ack, .write_error, .save_settings_command, .save_request, .read_param,
      .read_value, .bcd_switches, .upper_exceeded, .lower_exceeded, .warning_event, .ext_press_a, .ext_press_b,
      .internal_pressure_unit, .input_a_unit, .input_b_unit, .output_signal_type, .input_a_signal_type,
      .input_b_signal_type, .pressure_decimals_enable, .input_a_temp_decimals_enable, .input_a_press_decimals_enable,
      .input_b_humid_decimals_enable, .input_b_press_decimals_enable, .relay_ack_enable, .device_address,
      .relay_upper, .relay_lower, .sound_on);
   monitor_host_model monitor_host_model_inst (.clock, .write_strobe, .write_param, .write_value,
      .write_terminator, .write_ack, .write_error);
   always #20 clock = ~clock;
   // ==========================================================
   // Helpers
   function automatic logic [16:0] view(input logic [7:0] p);
      case (p)
         PARAM_EXT_PRESSURE: return {1'b1, 14'h0, ext_press_a, ext_press_b};
         PARAM_INT_UNIT: return {1'b1, 14'h0, internal_pressure_unit};
         PARAM_A_UNIT: return {1'b1, 14'h0, input_a_unit};
         PARAM_B_UNIT: return {1'b1, 14'h0, input_b_unit};
         PARAM_OUT_SIGNAL: return {1'b1, 14'h0, output_signal_type};
         PARAM_A_SIGNAL: return {1'b1, 14'h0, input_a_signal_type};
         PARAM_B_SIGNAL: return {1'b1, 14'h0, input_b_signal_type};
         PARAM_DEC_P: return {1'b1, 15'h0, pressure_decimals_enable};
         PARAM_DEC_AT: return {1'b1, 15'h0, input_a_temp_decimals_enable};
         PARAM_DEC_AP: return {1'b1, 15'h0, input_a_press_decimals_enable};
         PARAM_DEC_BH: return {1'b1, 15'h0, input_b_humid_decimals_enable};
         PARAM_DEC_BP: return {1'b1, 15'h0, input_b_press_decimals_enable};
         PARAM_RELAY_ACK: return {1'b1, 15'h0, relay_ack_enable};
         default: return 17'h00000;
      endcase
   endfunction : view
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] p, input logic [15:0] v, input logic [7:0] t = ASCII_CR, input int n = 1);
      monitor_host_model_inst.send(p, v, t, n, res);
   endtask : wr
   task automatic test_done();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // ==========================================================
   // Watchdog; the longest wait is the millisecond relay delay
   initial begin
      #(90000 * 40);
      error_cnt++;
      test_done();
   end
   // ==========================================================
   // Tests
   initial begin
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      foreach (rows[i]) begin
         for (int c = 0; c <= rows[i].top + 1 && c < 3; c++) begin
            want = (16'(c) > rows[i].top) ? rows[i].top : 16'(c);
            wr(rows[i].p, 16'(c));
            check(res[1:0], {16'(c) <= rows[i].top, 16'(c) > rows[i].top});
            if (view(rows[i].p) !== 17'h00000) check(view(rows[i].p), {1'b1, want});
            read_param = rows[i].p;
            @(negedge clock);
            check(read_value, want);
         end
         if (rows[i].top > 16'h0001 && rows[i].top < 16'h0010) begin
            wr(rows[i].p, rows[i].top - 16'h0001, ASCII_CR, 2);
            check(res, 4'hA);
            check(view(rows[i].p) & 17'h0FFFF, rows[i].p == PARAM_RELAY_MASK ? 17'h0 : rows[i].top);
            wr(rows[i].p, rows[i].top + 16'h0001);
            check(res[1:0], 2'h1);
         end
      end
      wr(PARAM_EXT_PRESSURE, 16'h0001, 8'h0A);
      check({res[1:0], ext_press_a, ext_press_b}, 4'h7);
      wr(PARAM_DEV_ADDR, 16'h0000);
      check({res[1:0], device_address}, 10'h142);
      wr(8'h1F, 16'h0000);
      check(res[1:0], 2'h1);
      wr(PARAM_RELAY1_TIME, 16'h0000);
      wr(PARAM_RELAY2_TIME, 16'h0000);
      wr(PARAM_RELAY_MASK, 16'h0002);
      upper_exceeded = 3'h5;
      repeat (10) @(negedge clock);
      check(relay_upper, 1'b0);
      upper_exceeded = 3'h2;
      lower_exceeded = 3'h2;
      repeat (6) @(negedge clock);
      check({relay_upper, relay_lower}, 2'h3);
      wr(PARAM_RELAY_MASK, 16'h0000);
      repeat (4) @(negedge clock);
      check({relay_upper, relay_lower}, 2'h0);
      wr(PARAM_RELAY1_TIME, 16'h0001);
      wr(PARAM_RELAY_MASK, 16'h0004);
      upper_exceeded = 3'h4;
      repeat (20000) @(negedge clock);
      check(relay_upper, 1'b0);
      for (int n = 0; n < 30100 && relay_upper !== 1'b1; n++) @(negedge clock);
      check(relay_upper, 1'b1);
      wr(PARAM_SOUND_LEN, 16'h0001);
      warning_event = 1'b1;
      for (int n = 0; n < 8 && sound_on !== 1'b1; n++) @(negedge clock);
      check(sound_on, 1'b1);
      wr(PARAM_SOUND, 16'h0000);
      repeat (3) @(negedge clock);
      check(sound_on, 1'b0);
      save_settings_command = 1'b1;
      @(negedge clock);
      check(save_request, 1'b1);
      save_settings_command = 1'b0;
      rstn = 1'b0;
      repeat (2) @(negedge clock);
      check({ext_press_a, internal_pressure_unit, relay_ack_enable, relay_upper, device_address}, 13'h0);
      rstn = 1'b1;
      wr(PARAM_EXT_PRESSURE, 16'h0002);
      check({res[1:0], ext_press_a, ext_press_b}, 4'hA);
      test_done();
   end
endmodule : tb
